// ===== verilog/ssp_params.svh
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// register indices reached through the index/data pair
`define SSP_IDX_CHIP_ID      8'h00
`define SSP_IDX_PIN_STATUS   8'h01
`define SSP_IDX_POWER_GATE   8'h02
`define SSP_IDX_GEN_CTRL     8'h03
`define SSP_IDX_MISC_CTRL    8'h20
`define SSP_IDX_EXT_CTRL     8'h21

// host port select: index port or data port
`define SSP_PORT_INDEX       1'b0
`define SSP_PORT_DATA        1'b1

// chip identification fields
`define SSP_IFACE_MEM_IO     2'h2
`define SSP_ID_RSVD          2'h0

// power gate fields
`define SSP_PG_CARD_EN       7
`define SSP_PG_AUTO_PWR      5
`define SSP_PG_VCC_PWR       4
`define SSP_PG_VPP_HI        1
`define SSP_PG_VPP_LO        0

// general control, misc and extension fields
`define SSP_GC_CARD_TYPE     5
`define SSP_MC_VCC_3V3       1
`define SSP_EC_VCC_LOCK      0
`define SSP_EC_APO_DIS       1

// status fields
`define SSP_ST_ALWAYS_ONE    7
`define SSP_ST_PWR_ON        6
`define SSP_ST_READY         5
`define SSP_ST_WPROT         4
`define SSP_ST_CD_SECOND     3
`define SSP_ST_CD_FIRST      2
`define SSP_ST_BATT_SECOND   1
`define SSP_ST_BATT_FIRST    0

// reset value and unmapped-index read value
`define SSP_RST_BYTE         8'h00
`define SSP_UNMAPPED_READ    8'h00

`endif

// ===== verilog/ssp_pkg.sv
package ssp_pkg;

  typedef logic [7:0] ssp_byte_t;

  // socket personality selected by the card type bit
  typedef enum logic {
    SSP_MODE_MEMORY = 1'b0,
    SSP_MODE_IO     = 1'b1
  } ssp_mode_t;

  // programming supply request encoded in the power gate
  typedef enum logic [1:0] {
    SSP_VPP_OFF  = 2'h0,
    SSP_VPP_VCC  = 2'h1,
    SSP_VPP_HIGH = 2'h2,
    SSP_VPP_OFF2 = 2'h3
  } ssp_vpp_t;

endpackage

// ===== verilog/ssp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // two stages; the first is seen by the second and nothing else
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    // reset to the pulled-up idle level, so no false presence or removal
    // edge shows up while the stages refill after reset
    if (!nrst_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else if (ce_i) begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/ssp_power.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_power
  import ssp_pkg::*;
(
  input  wire logic     core_clk_i,
  input  wire logic     nrst_i,
  input  wire logic     ce_i,
  input  wire logic     card_present_i,
  input  wire logic     vcc_power_i,
  input  wire logic     auto_power_i,
  input  wire logic     vcc_3v3_i,
  input  wire ssp_vpp_t vpp_sel_i,
  input  wire logic     card_enable_i,
  output logic          supply_3v3_n_o,
  output logic          supply_5v_n_o,
  output logic          programming_supply_high_o,
  output logic          programming_supply_select_o,
  output logic          card_power_on_o,
  output logic          socket_drive_n_o
);

  logic next_power_on;
  logic next_drive;

  // supply only with vcc bit set and either auto-power off or card seated
  assign next_power_on = vcc_power_i && (!auto_power_i || card_present_i);
  // drivers float unless a card is seated and card enable is set
  assign next_drive    = card_present_i && card_enable_i;

  // reset forces every control inactive, whatever the registers hold
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      supply_3v3_n_o              <= 1'b1;
      supply_5v_n_o               <= 1'b1;
      programming_supply_high_o   <= 1'b0;
      programming_supply_select_o <= 1'b0;
      card_power_on_o             <= 1'b0;
      socket_drive_n_o            <= 1'b1;
    end else if (ce_i) begin
      supply_3v3_n_o              <= !(next_power_on && vcc_3v3_i);
      supply_5v_n_o               <= !(next_power_on && !vcc_3v3_i);
      programming_supply_high_o   <= next_power_on && (vpp_sel_i == SSP_VPP_HIGH);
      programming_supply_select_o <= next_power_on && (vpp_sel_i == SSP_VPP_VCC);
      card_power_on_o             <= next_power_on;
      socket_drive_n_o            <= !next_drive;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/ssp_socket_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

////////////////////////////////////////////////////////////////////////////////
module ssp_socket_ctrl
  import ssp_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h5  // arbitrary value
) (
  input  wire logic      core_clk_i,
  input  wire logic      nrst_i,
  input  wire logic      ce_i,
  // host side: index/data pair
  input  wire logic      host_port_i,
  input  wire logic      host_wr_i,
  input  wire logic      host_rd_i,
  input  wire ssp_byte_t host_wdata_i,
  output ssp_byte_t      host_rdata_o,
  output logic           host_rvalid_o,
  // card pins, as they arrive from the socket
  input  wire logic      card_detect_first_n_i,
  input  wire logic      card_detect_second_n_i,
  input  wire logic      battery_detect_first_pin_i,
  input  wire logic      battery_detect_second_pin_i,
  input  wire logic      write_protect_width_pin_i,
  input  wire logic      card_ready_request_pin_i,
  // supply switch controls, socket drive enable and card mode output
  output logic           supply_3v3_n_o,
  output logic           supply_5v_n_o,
  output logic           programming_supply_high_o,
  output logic           programming_supply_select_o,
  output logic           socket_drive_n_o,
  output logic           card_mode_io_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [5:0] pins_raw;
  logic [5:0] pins_sync;
  logic       det_first_n;
  logic       det_second_n;
  logic       batt_first;
  logic       batt_second;
  logic       wprot;
  logic       ready;

  assign pins_raw = {card_ready_request_pin_i,
                     write_protect_width_pin_i,
                     battery_detect_second_pin_i,
                     battery_detect_first_pin_i,
                     card_detect_second_n_i,
                     card_detect_first_n_i};

  // card pins change at any time relative to our clock
  ssp_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .async_i    (pins_raw),
    .sync_o     (pins_sync)
  );

  assign det_first_n  = pins_sync[0];
  assign det_second_n = pins_sync[1];
  assign batt_first   = pins_sync[2];
  assign batt_second  = pins_sync[3];
  assign wprot = pins_sync[4];
  assign ready = pins_sync[5];

  //////////////////////////////////////////////////////////////////////////////
  // card presence and removal

  logic card_present;
  logic card_present_q;
  logic card_removed;

  // only both detects low counts as a seated card
  assign card_present = !det_first_n && !det_second_n;
  assign card_removed = card_present_q && !card_present;

  // presence history, so a removal shows as a one-cycle event
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      card_present_q <= 1'b0;
    end else if (ce_i) begin
      card_present_q <= card_present;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host access decode

  ssp_byte_t index_reg;
  logic      wr_index;
  logic      wr_data;
  logic      rd_data;
  logic      rd_index;
  logic      wr_power;
  logic      wr_gen;
  logic      wr_misc;
  logic      wr_ext;

  assign wr_index = host_wr_i && (host_port_i == `SSP_PORT_INDEX);
  assign wr_data  = host_wr_i && (host_port_i == `SSP_PORT_DATA);
  assign rd_index = host_rd_i && (host_port_i == `SSP_PORT_INDEX);
  assign rd_data  = host_rd_i && (host_port_i == `SSP_PORT_DATA);
  assign wr_power = wr_data && (index_reg == `SSP_IDX_POWER_GATE);
  assign wr_gen   = wr_data && (index_reg == `SSP_IDX_GEN_CTRL);
  assign wr_misc  = wr_data && (index_reg == `SSP_IDX_MISC_CTRL);
  assign wr_ext   = wr_data && (index_reg == `SSP_IDX_EXT_CTRL);

  // the index stays put between accesses; software reuses it
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      index_reg <= `SSP_RST_BYTE;
    end else if (ce_i && wr_index) begin
      index_reg <= host_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  ssp_byte_t power_gate;
  ssp_byte_t gen_ctrl;
  ssp_byte_t misc_ctrl;
  ssp_byte_t ext_ctrl;
  ssp_byte_t next_power_gate;
  logic      vcc_locked;
  logic      next_vcc_bit;

  assign vcc_locked = ext_ctrl[`SSP_EC_VCC_LOCK];

  // a locked vcc bit keeps its old value across power gate writes
  assign next_vcc_bit = vcc_locked ? power_gate[`SSP_PG_VCC_PWR]
                                   : host_wdata_i[`SSP_PG_VCC_PWR];

  // removal beats a same-cycle write: powering an empty socket is the
  // worse failure, and software must write again anyway
  always_comb begin
    next_power_gate = power_gate;
    if (wr_power) begin
      next_power_gate                  = host_wdata_i;
      next_power_gate[`SSP_PG_VCC_PWR] = next_vcc_bit;
    end
    if (card_removed && !ext_ctrl[`SSP_EC_APO_DIS]) begin
      next_power_gate[`SSP_PG_VCC_PWR] = 1'b0;
    end
  end

  // power gate: all zero out of reset, card unpowered and floating
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_gate <= `SSP_RST_BYTE;
    end else if (ce_i) begin
      power_gate <= next_power_gate;
    end
  end

  // general control carries the card type bit among others
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gen_ctrl <= `SSP_RST_BYTE;
    end else if (ce_i && wr_gen) begin
      gen_ctrl <= host_wdata_i;
    end
  end

  // misc control holds the 3.3 v select
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc_ctrl <= `SSP_RST_BYTE;
    end else if (ce_i && wr_misc) begin
      misc_ctrl <= host_wdata_i;
    end
  end

  // extension control holds the lock and auto-power-off disable
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_ctrl <= `SSP_RST_BYTE;
    end else if (ce_i && wr_ext) begin
      ext_ctrl <= host_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // socket mode

  ssp_mode_t card_mode;

  // the dual-function pins change meaning with this bit
  assign card_mode = ssp_mode_t'(gen_ctrl[`SSP_GC_CARD_TYPE]);

  // the socket pin muxes outside need the mode directly
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      card_mode_io_o <= 1'b0;
    end else if (ce_i) begin
      card_mode_io_o <= (card_mode == SSP_MODE_IO);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // supply and drive control

  logic card_power_on;

  ssp_power u_power (
    .core_clk_i                  (core_clk_i),
    .nrst_i                      (nrst_i),
    .ce_i                        (ce_i),
    .card_present_i              (card_present),
    .vcc_power_i                 (power_gate[`SSP_PG_VCC_PWR]),
    .auto_power_i                (power_gate[`SSP_PG_AUTO_PWR]),
    .vcc_3v3_i                   (misc_ctrl[`SSP_MC_VCC_3V3]),
    .vpp_sel_i                   (ssp_vpp_t'(power_gate[`SSP_PG_VPP_HI:`SSP_PG_VPP_LO])),
    .card_enable_i               (power_gate[`SSP_PG_CARD_EN]),
    .supply_3v3_n_o              (supply_3v3_n_o),
    .supply_5v_n_o               (supply_5v_n_o),
    .programming_supply_high_o   (programming_supply_high_o),
    .programming_supply_select_o (programming_supply_select_o),
    .card_power_on_o             (card_power_on),
    .socket_drive_n_o            (socket_drive_n_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read-only images

  ssp_byte_t chip_identification;
  ssp_byte_t socket_pin_status;
  logic      mem_mode;

  assign mem_mode = (card_mode == SSP_MODE_MEMORY);

  // interface type, zero reserved field, fixed revision
  assign chip_identification = {`SSP_IFACE_MEM_IO,
                                `SSP_ID_RSVD,
                                REV_CODE};

  // ready and write protect mean nothing for io cards, so read zero;
  // bit 0 is the status-change pin in io mode, the same wire
  always_comb begin
    socket_pin_status                     = `SSP_RST_BYTE;
    socket_pin_status[`SSP_ST_ALWAYS_ONE] = 1'b1;
    socket_pin_status[`SSP_ST_PWR_ON]     = card_power_on;
    socket_pin_status[`SSP_ST_READY]      = mem_mode && ready;
    socket_pin_status[`SSP_ST_WPROT]      = mem_mode && wprot;
    socket_pin_status[`SSP_ST_CD_SECOND]   = !det_second_n;
    socket_pin_status[`SSP_ST_CD_FIRST]    = !det_first_n;
    socket_pin_status[`SSP_ST_BATT_SECOND] = batt_second;
    socket_pin_status[`SSP_ST_BATT_FIRST]  = batt_first;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  ssp_byte_t read_mux;

  // unmapped indices read a fixed value so software sees no garbage
  always_comb begin
    unique case (index_reg)
      `SSP_IDX_CHIP_ID:    read_mux = chip_identification;
      `SSP_IDX_PIN_STATUS: read_mux = socket_pin_status;
      `SSP_IDX_POWER_GATE: read_mux = power_gate;
      `SSP_IDX_GEN_CTRL:   read_mux = gen_ctrl;
      `SSP_IDX_MISC_CTRL:  read_mux = misc_ctrl;
      `SSP_IDX_EXT_CTRL:   read_mux = ext_ctrl;
      default:             read_mux = `SSP_UNMAPPED_READ;
    endcase
  end

  // read data is captured once per strobe and then held
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      host_rdata_o  <= `SSP_RST_BYTE;
      host_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      host_rvalid_o <= host_rd_i;
      if (rd_data) begin
        host_rdata_o <= read_mux;
      end else if (rd_index) begin
        host_rdata_o <= index_reg;
      end
    end
  end

endmodule

`default_nettype wire

// ===== test/ssp_socket_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_socket_ctrl_props
  import ssp_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      nrst_i,
  input wire logic      ce_i,
  input wire logic      host_port_i,
  input wire logic      host_wr_i,
  input wire logic      host_rd_i,
  input wire ssp_byte_t host_wdata_i,
  input wire ssp_byte_t host_rdata_o,
  input wire logic      host_rvalid_o,
  input wire logic      card_detect_first_n_i,
  input wire logic      card_detect_second_n_i,
  input wire logic      battery_detect_first_pin_i,
  input wire logic      battery_detect_second_pin_i,
  input wire logic      write_protect_width_pin_i,
  input wire logic      card_ready_request_pin_i,
  input wire logic      supply_3v3_n_o,
  input wire logic      supply_5v_n_o,
  input wire logic      programming_supply_high_o,
  input wire logic      programming_supply_select_o,
  input wire logic      socket_drive_n_o,
  input wire logic      card_mode_io_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // either supply switch closed; presence is judged three edges back, after the synchronisers
  wire logic sup_on  = !supply_3v3_n_o || !supply_5v_n_o;
  wire logic present = !card_detect_first_n_i && !card_detect_second_n_i;

  ////////////////////////////////////////////////////////////////////////////
  a_release_outputs_idle: assert property ($rose(nrst_i) |-> supply_3v3_n_o
    && supply_5v_n_o && socket_drive_n_o && !programming_supply_high_o
    && !programming_supply_select_o) else $error("outputs active at reset release");
  a_read_answered: assert property (host_rd_i && ce_i |=> host_rvalid_o)
    else $error("read not answered next cycle");
  a_no_stray_answer: assert property (!(host_rd_i && ce_i) |=> !host_rvalid_o)
    else $error("answer without read");
  a_rdata_holds: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
    else $error("read data moved without answer");
  a_one_supply: assert property (!(!supply_3v3_n_o && !supply_5v_n_o))
    else $error("both supplies on");
  a_vpp_exclusive: assert property (!(programming_supply_high_o
    && programming_supply_select_o)) else $error("both vpp controls on");
  a_vpp_needs_vcc: assert property ((programming_supply_high_o
    || programming_supply_select_o) |-> sup_on) else $error("vpp on without vcc");
  a_drive_needs_card: assert property (!socket_drive_n_o |-> $past(present, 3))
    else $error("socket driven without card");
endmodule

bind ssp_socket_ctrl ssp_socket_ctrl_props i_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .host_port_i(host_port_i),
  .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
  .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
  .card_detect_first_n_i(card_detect_first_n_i), .card_detect_second_n_i(card_detect_second_n_i),
  .battery_detect_first_pin_i(battery_detect_first_pin_i),
  .battery_detect_second_pin_i(battery_detect_second_pin_i),
  .write_protect_width_pin_i(write_protect_width_pin_i),
  .card_ready_request_pin_i(card_ready_request_pin_i), .supply_3v3_n_o(supply_3v3_n_o),
  .supply_5v_n_o(supply_5v_n_o), .programming_supply_high_o(programming_supply_high_o),
  .programming_supply_select_o(programming_supply_select_o),
  .socket_drive_n_o(socket_drive_n_o), .card_mode_io_o(card_mode_io_o));

`default_nettype wire

// ===== test/ssp_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_card_model (
  input  wire logic [1:0] seat_i,
  input  wire logic [3:0] lvl_i,
  output logic            card_detect_first_n_o,
  output logic            card_detect_second_n_o,
  output logic            card_ready_request_pin_o,
  output logic            write_protect_width_pin_o,
  output logic            battery_detect_second_pin_o,
  output logic            battery_detect_first_pin_o
);
  // each detect contact grounds its pin once seated, so a half-inserted card seats one
  assign card_detect_first_n_o  = !seat_i[0];
  assign card_detect_second_n_o = !seat_i[1];
  // signal contacts only touch when fully seated; otherwise socket pull-ups win
  wire logic [3:0] lvl = (&seat_i) ? lvl_i : 4'hf;
  assign card_ready_request_pin_o    = lvl[3];
  assign write_protect_width_pin_o   = lvl[2];
  assign battery_detect_second_pin_o = lvl[1];
  assign battery_detect_first_pin_o  = lvl[0];
endmodule

`default_nettype wire

// ===== test/socket_status_power_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module socket_status_power_control_bench import ssp_pkg::*;;
  localparam logic [3:0] REV = 4'ha; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic port = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  ssp_byte_t wd = 8'h00;
  logic [1:0] seat = 2'h0;
  logic [3:0] lvl = 4'h0;
  ssp_byte_t rdat;
  logic rv, det1_n, det2_n, rdy, wp, bv2, bv1, s33_n, s5_n, vh, vs, drv_n, mio;
  int failures = 0;
  int checked = 0;
  wire logic [7:0] outs = {2'h0, mio, s33_n, s5_n, vh, vs, drv_n};

  always #4 clk = !clk;

  ssp_socket_ctrl #(.REV_CODE(REV)) i_dut (.core_clk_i(clk), .nrst_i(rst_n), .ce_i(ce),
    .host_port_i(port), .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wd),
    .host_rdata_o(rdat), .host_rvalid_o(rv), .card_detect_first_n_i(det1_n),
    .card_detect_second_n_i(det2_n), .battery_detect_first_pin_i(bv1),
    .battery_detect_second_pin_i(bv2), .write_protect_width_pin_i(wp),
    .card_ready_request_pin_i(rdy), .supply_3v3_n_o(s33_n), .supply_5v_n_o(s5_n),
    .programming_supply_high_o(vh), .programming_supply_select_o(vs),
    .socket_drive_n_o(drv_n), .card_mode_io_o(mio));
  ssp_card_model i_card (.seat_i(seat), .lvl_i(lvl), .card_detect_first_n_o(det1_n),
    .card_detect_second_n_o(det2_n), .card_ready_request_pin_o(rdy),
    .write_protect_width_pin_o(wp), .battery_detect_second_pin_o(bv2),
    .battery_detect_first_pin_o(bv1));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one host access; strobe drops at the edge that takes it
  task automatic acc(input logic p, input logic w, input ssp_byte_t d);
    @(posedge clk);
    port <= p;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wr_reg(input ssp_byte_t i, input ssp_byte_t d);
    acc(1'b0, 1'b1, i);
    acc(1'b1, 1'b1, d);
  endtask

  // answer lands on the taking edge, so it is looked at just after it
  task automatic rc(input ssp_byte_t i, input ssp_byte_t e);
    acc(1'b0, 1'b1, i);
    acc(1'b1, 1'b0, 8'h00);
    #1;
    chk({7'h0, rv}, 8'h01);
    chk(rdat, e);
  endtask

  // pins need two sync stages plus the output flop
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask

  function automatic ssp_byte_t st(input logic [1:0] s, input logic [3:0] l, input logic io,
                                   input logic p);
    logic [3:0] e;
    e = (&s) ? l : 4'hf;
    return {1'b1, p, e[3] & !io, e[2] & !io, s, e[1:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_basic();
    chk(outs, 8'h19);
    rc(8'h00, {2'h2, 2'h0, REV});
    wr_reg(8'h00, 8'hff);
    rc(8'h00, {2'h2, 2'h0, REV});
    rc(8'h02, 8'h00);
    rc(8'h7f, 8'h00);
    acc(1'b0, 1'b0, 8'h00);
    #1;
    chk(rdat, 8'h7f);
    @(posedge clk);
    ce <= 1'b0;
    acc(1'b1, 1'b0, 8'h00);
    #1;
    chk({7'h0, rv}, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  // every seat and pin combination, memory then io personality
  task automatic t_status();
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h03, m[0] ? 8'h20 : 8'h00);
      for (int k = 0; k < 64; k++) begin
        seat <= k[5:4];
        lvl <= k[3:0];
        settle();
        rc(8'h01, st(k[5:4], k[3:0], m[0], 1'b0));
      end
      chk(outs, {2'h0, m[0], 5'h19});
    end
    wr_reg(8'h03, 8'h00);
  endtask

  task automatic t_power();
    logic [1:0] vp;
    seat <= 2'h3;
    lvl <= 4'h5;
    for (int k = 0; k < 16; k++) begin
      vp = k[1:0];
      wr_reg(8'h20, {6'h0, k[2], 1'b0});
      wr_reg(8'h02, {2'h2, k[3], 1'b1, 2'h0, vp});
      settle();
      chk(outs, {3'h0, !k[2], k[2], vp == 2'h2, vp == 2'h1, 1'b0});
      rc(8'h01, st(2'h3, 4'h5, 1'b0, 1'b1));
    end
  endtask

  task automatic t_remove();
    wr_reg(8'h20, 8'h00);
    wr_reg(8'h02, 8'h90);
    seat <= 2'h0;
    settle();
    rc(8'h02, 8'h80);
    chk(outs, 8'h19);
    wr_reg(8'h21, 8'h02);
    seat <= 2'h3;
    settle();
    wr_reg(8'h02, 8'h90);
    seat <= 2'h1;
    settle();
    rc(8'h02, 8'h90);
    chk(outs, 8'h11);
    rc(8'h01, st(2'h1, 4'h5, 1'b0, 1'b1));
    wr_reg(8'h02, 8'hb0);
    settle();
    chk(outs, 8'h19);
    rc(8'h01, st(2'h1, 4'h5, 1'b0, 1'b0));
  endtask

  task automatic t_lock();
    wr_reg(8'h21, 8'h03);
    seat <= 2'h3;
    settle();
    wr_reg(8'h02, 8'h80);
    rc(8'h02, 8'h90);
    wr_reg(8'h02, 8'h00);
    rc(8'h02, 8'h10);
    wr_reg(8'h21, 8'h00);
    wr_reg(8'h02, 8'h80);
    settle();
    chk(outs, 8'h18);
    rc(8'h02, 8'h80);
  endtask

  task automatic t_midreset();
    wr_reg(8'h02, 8'h90);
    settle();
    chk(outs, 8'h10);
    @(posedge clk);
    rst_n <= 1'b0;
    settle();
    chk(outs, 8'h19);
    @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h02, 8'h00);
    rc(8'h21, 8'h00);
    rc(8'h01, st(2'h3, 4'h5, 1'b0, 1'b0));
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_basic();
    t_status();
    t_power();
    t_remove();
    t_lock();
    t_midreset();
    close_out();
  end
endmodule

`default_nettype wire
